// file: testbench/rcd_redriver_ctrl_tb.sv
// Purpose: Self-checking bench of the redriver control block.
// Assumes: Short poll period; straps held across each reset release.
// Notes: Read results are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
module rcd_redriver_ctrl_tb;
	localparam int POLL = 12;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] eql = 2'h0, eqh = 2'h0, gain = 2'h3, mode = 2'h0, det = 2'h3, adr = 2'h0;
	logic pd = 1'b0, sel = 1'b0, rd = 1'b0, wr = 1'b0, ser_o, stby, s;
	logic [3:0] attach = 4'h0, late = 4'h0, aa = 4'h0, be = 4'h0, term, rxon, probe, found;
	logic [31:0] wd = 32'h0, rdata, ctrl, exp_q [$];
	logic wreq;
	logic [15:0] eq_o;
	logic [1:0] gain_o;
	logic [6:0] a01, a23;
	int n_errors = 0;
	int tests_run = 0;
	int pcnt [4];
	int last [4];
	int cyc = 0;
	bit chk_per = 1'b0;
	rcd_redriver_ctrl #(.NUM_CH(4), .POLL_CYCLES(POLL)) u_rcd_redriver_ctrl (.clk(clk), .nrst(nrst),
		.eq_strap_low(eql), .eq_strap_high(eqh), .gain_strap(gain), .mode_strap(mode),
		.far_end_detect_strap(det), .addr_strap(adr), .power_down_pin(pd), .mux_select_pin(sel),
		.term_present(term), .avs_address(aa), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq), .equalization_index(eq_o),
		.flat_gain(gain_o), .serial_mode(ser_o), .addr_ch01(a01), .addr_ch23(a23), .standby(stby),
		.rx_term_on(rxon), .tx_probe(probe), .term_found(found));
	rcd_term_model u_rcd_term_model (.clk(clk), .nrst(nrst), .attach(attach), .late(late),
		.tx_probe(probe), .term_present(term));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Reads are compared on the edge where waitrequest is seen low, the only edge that carries data.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rd === 1'b1 && wreq === 1'b0) begin
			if (exp_q.size() == 0)
				check("unasked read", 32'h1, 32'h0);
			else
				check("readdata", rdata, exp_q.pop_front());
		end
		for (int c = 0; c < 4; c++)
			if (probe[c] === 1'b1) begin
				if (chk_per && last[c] > 0)
					check("probe period", cyc - last[c], POLL);
				last[c] = cyc;
				pcnt[c]++;
			end
	end
	task automatic bus(bit w, logic [3:0] a, logic [31:0] d, logic [3:0] b, logic [31:0] e);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		aa <= a;
		wd <= d;
		be <= b;
		if (!w)
			exp_q.push_back(e);
		// The request stands until a rising edge samples waitrequest low; only the watchdog ends a hang.
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic clr();
		@(negedge clk);
		for (int c = 0; c < 4; c++) begin
			pcnt[c] = 0;
			last[c] = 0;
		end
	endtask
	task automatic boot(logic [1:0] l, logic [1:0] h, logic [1:0] g, logic [1:0] d, logic [1:0] ad);
		@(posedge clk);
		nrst <= 1'b0;
		eql <= l;
		eqh <= h;
		gain <= g;
		det <= d;
		adr <= ad;
		mode <= 2'h0;
		pd <= 1'b0;
		repeat (12) @(posedge clk);
		clr();
		@(posedge clk);
		nrst <= 1'b1;
		ctrl = rcd_pkg::CTRL_RST;
		repeat (10) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic allstart(string what);
		clr();
		repeat (9) @(posedge clk);
		@(negedge clk);
		for (int c = 0; c < 4; c++)
			check(what, pcnt[c], 1);
		check(what, found, 4'b1011);
	endtask
	function automatic logic [6:0] exp_addr(logic [1:0] m, logic [1:0] a);
		return ((m == rcd_pkg::LVL_L2) ? 7'h20 : rcd_pkg::SLAVE_ADDR_BASE) + {4'h0, a, 1'b0};
	endfunction
	initial begin
		logic [1:0] g;
		logic [1:0] ad;
		logic [31:0] d;
		logic [15:0] eqx;
		logic [1:0] mc;
		d = $urandom(32'hfe05);
		for (int i = 0; i < 16; i++) begin
			g = $urandom();
			ad = $urandom();
			boot(i[1:0], i[3:2], g, rcd_pkg::LVL_L3, ad);
			eqx = {4{i[3:0]}};
			bus(0, rcd_pkg::REG_STRAPS, 0, 4'hF, {16'h0000, 1'b1, 5'h0, ad, 2'h3, g, i[3:0]});
			@(posedge clk);
			eql <= ~eql;
			eqh <= ~eqh;
			gain <= ~gain;
			adr <= ~adr;
			repeat (8) @(posedge clk);
			// Modes run L1, L2, L0, L3 so that a direct change from serial to pin control is seen.
			for (int m = 0; m < 4; m++) begin
				mc = (m == 2) ? 2'h0 : (m == 3) ? 2'h3 : 2'(m + 1);
				@(posedge clk);
				mode <= mc;
				repeat (6) @(posedge clk);
				if (m == 1) begin
					d = $urandom() & 32'h0003_FFFF;
					bus(1, rcd_pkg::REG_CTRL, d, 4'hF, 0);
					ctrl = d;
					d = $urandom() & 32'h0003_FFFF;
					bus(1, rcd_pkg::REG_CTRL, d, 4'h4, 0);
					ctrl = {14'h0000, d[17:16], ctrl[15:0]};
					bus(0, rcd_pkg::REG_CTRL, 0, 4'hF, ctrl);
				end
				@(negedge clk);
				s = (mc == 2'h1 || mc == 2'h2);
				check("serial", ser_o, s);
				check("eq", eq_o, s ? ctrl[15:0] : eqx);
				check("gain", gain_o, s ? ctrl[17:16] : g);
				check("addr01", a01, exp_addr(mc, ad));
				check("addr23", a23, exp_addr(mc, ad) + 7'h01);
			end
		end
		@(posedge clk);
		attach <= 4'b1011;
		late <= 4'b1000;
		chk_per = 1'b1;
		boot(2'h0, 2'h0, 2'h3, rcd_pkg::LVL_L3, 2'h0);
		check("powerup probes", pcnt[0] + pcnt[1] + pcnt[2] + pcnt[3], 4);
		check("found", {rxon, found}, 8'h33);
		repeat (36) @(posedge clk);
		@(negedge clk);
		chk_per = 1'b0;
		check("late found", {rxon, found}, 8'hBB);
		check("late probes", pcnt[3], 3);
		clr();
		bus(1, rcd_pkg::REG_DET_TRIG, 32'h0000_0001, 4'h1, 0);
		repeat (4) @(posedge clk);
		@(negedge clk);
		check("trig ch0", pcnt[0], 1);
		check("trig others", pcnt[1] + pcnt[3], 0);
		check("refound", found, 4'b1011);
		bus(0, rcd_pkg::REG_DET_TRIG, 0, 4'hF, 0);
		bus(0, 4'h2, 0, 4'hF, 0);
		bus(1, rcd_pkg::REG_STATUS, 32'hFFFF_FFFF, 4'hF, 0);
		@(posedge clk) pd <= 1'b1;
		repeat (8) @(posedge clk);
		clr();
		repeat (30) @(posedge clk);
		@(negedge clk);
		check("standby", stby, 1'b1);
		check("standby term", {rxon, found}, 8'h00);
		check("standby probes", pcnt[0] + pcnt[1] + pcnt[2] + pcnt[3], 0);
		bus(0, rcd_pkg::REG_STATUS, 0, 4'hF, 32'h0000_0100);
		@(posedge clk) pd <= 1'b0;
		allstart("pd release");
		@(posedge clk) sel <= 1'b1;
		allstart("sel edge");
		boot(2'h0, 2'h0, 2'h3, rcd_pkg::LVL_L0, 2'h0);
		repeat (30) @(posedge clk);
		@(negedge clk);
		check("buffer", {rxon, found}, 8'hF0);
		check("buffer probes", pcnt[0] + pcnt[1] + pcnt[2] + pcnt[3], 0);
		bus(0, rcd_pkg::REG_STATUS, 0, 4'hF, 32'h0000_00F0);
		@(posedge clk) pd <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		check("buffer standby", rxon, 4'h0);
		finish_test();
	end
	initial begin
		repeat (6000) @(posedge clk);
		n_errors++;
		finish_test();
	end
endmodule // rcd_redriver_ctrl_tb

// file: testbench/rcd_term_model.sv
// Purpose: Far-end receiver termination seen by the four detect channels.
// Assumes: One tx_probe pulse per detect attempt.
// Notes: A late channel powers its termination only after two probes.
`timescale 1ns/1ps
module rcd_term_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] attach,
	input wire logic [3:0] late,
	input wire logic [3:0] tx_probe,
	output logic [3:0] term_present
);
	logic [1:0] seen [4];
	always_ff @(posedge clk or negedge nrst) begin
		for (int c = 0; c < 4; c++) begin
			if (!nrst)
				seen[c] <= 2'h0;
			else if (tx_probe[c] && seen[c] != 2'h2)
				seen[c] <= seen[c] + 2'h1;
		end
	end
	// A late receiver makes the transmitter keep polling before it is found.
	always_comb begin
		for (int c = 0; c < 4; c++)
			term_present[c] = attach[c] && (!late[c] || seen[c] == 2'h2);
	end
endmodule // rcd_term_model

// file: verilog/rcd_detect_chan.sv
// Purpose: Receiver-detect state machine of one channel.
// Assumes: term_present and standby are already in the clk domain.
// Notes: The probe period is POLL_CYCLES clocks from probe to probe.
`timescale 1ns/1ps
module rcd_detect_chan #(
	parameter int POLL_CYCLES = rcd_pkg::POLL_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic buffer_mode,
	input wire logic standby,
	input wire logic term_present,
	output logic tx_probe,
	output logic rx_term_on,
	output logic term_found
);
	localparam int CW = $clog2(POLL_CYCLES + 1);
	rcd_pkg::rcd_det_state_t state, next_state;
	logic [CW-1:0] cnt, next_cnt;
	logic next_tx_probe, next_rx_term_on, next_term_found;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_term_found = term_found;
		if (standby) begin
			next_state = rcd_pkg::RCD_IDLE;
			next_cnt = '0;
			next_term_found = 1'b0;
		end else if (buffer_mode) begin
			next_state = rcd_pkg::RCD_IDLE;
			next_term_found = 1'b0;
		end else begin
			unique case (state)
				rcd_pkg::RCD_IDLE: begin
					if (start) begin
						next_state = rcd_pkg::RCD_POLL;
					end
				end
				rcd_pkg::RCD_POLL: begin
					if (term_present) begin
						next_state = rcd_pkg::RCD_FOUND;
						next_term_found = 1'b1;
					end else begin
						// Load two short so the period counts the probe cycle as well.
						next_state = rcd_pkg::RCD_WAIT;
						next_cnt = CW'(POLL_CYCLES - 2);
					end
				end
				rcd_pkg::RCD_WAIT: begin
					if (start || cnt == '0) begin
						next_state = rcd_pkg::RCD_POLL;
					end else begin
						next_cnt = cnt - CW'(1);
					end
				end
				rcd_pkg::RCD_FOUND: begin
					// Once found, only standby, buffer mode or an explicit start clears the result.
					if (start) begin
						next_state = rcd_pkg::RCD_POLL;
						next_term_found = 1'b0;
					end
				end
			endcase
		end
		next_tx_probe = (next_state == rcd_pkg::RCD_POLL);
		next_rx_term_on = (!standby && buffer_mode) || (next_state == rcd_pkg::RCD_FOUND);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= rcd_pkg::RCD_IDLE;
			cnt <= '0;
			tx_probe <= 1'b0;
			rx_term_on <= 1'b0;
			term_found <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			tx_probe <= next_tx_probe;
			rx_term_on <= next_rx_term_on;
			term_found <= next_term_found;
		end
	end

	AST_STBY_HIZ: assert property (@(posedge clk) disable iff (!nrst) standby |=> (!rx_term_on && !term_found && state == rcd_pkg::RCD_IDLE)) else $error("standby did not force high impedance");
	AST_BUFFER_50: assert property (@(posedge clk) disable iff (!nrst) (buffer_mode && !standby) |=> (rx_term_on && state == rcd_pkg::RCD_IDLE)) else $error("buffer mode did not hold termination");
	AST_PROBE_ONE: assert property (@(posedge clk) disable iff (!nrst) tx_probe |=> !tx_probe) else $error("probe longer than one cycle");
	AST_FOUND: assert property (@(posedge clk) disable iff (!nrst) (state == rcd_pkg::RCD_POLL && term_present && !standby && !buffer_mode) |=> (term_found && rx_term_on)) else $error("termination not recorded");
	AST_RETRY: assert property (@(posedge clk) disable iff (!nrst) (state == rcd_pkg::RCD_POLL && !term_present && !standby && !buffer_mode) |=> (state == rcd_pkg::RCD_WAIT && !rx_term_on)) else $error("no retry after empty probe");
endmodule // rcd_detect_chan

// file: verilog/rcd_pkg.sv
// Purpose: Shared constants and types of the redriver control block.
// Assumes: A 100 MHz core clock and digitised four-level strap codes.
// Notes: Register offsets are byte addresses on the Avalon-MM slave.
package rcd_pkg;
	localparam int LVL_W = 2;
	localparam logic [1:0] LVL_L0 = 2'h0;
	localparam logic [1:0] LVL_L1 = 2'h1;
	localparam logic [1:0] LVL_L2 = 2'h2;
	localparam logic [1:0] LVL_L3 = 2'h3;
	localparam int NUM_CH = 4;
	localparam int EQ_W = 4;
	localparam int ADDR_W = 7;
	localparam logic [6:0] SLAVE_ADDR_BASE = 7'h18;
	localparam logic [6:0] SLAVE_ADDR_TOP = 7'h26;
	localparam logic [6:0] SLAVE_ADDR_BANK_HI = 7'h01;
	localparam int CLK_MHZ = 100;
	localparam int POLL_US = 150;
	localparam int POLL_CYCLES = POLL_US * CLK_MHZ;
	localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;
	localparam int AVS_ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int BE_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_DET_TRIG = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_STRAPS = 4'hC;
	localparam int CTRL_GAIN_LSB = 16;
	localparam logic [31:0] CTRL_RST = 32'h0003_0000;
	localparam int ST_FOUND_LSB = 0;
	localparam int ST_TERM_LSB = 4;
	localparam int ST_STANDBY = 8;
	localparam int ST_SERIAL = 9;
	localparam int ST_MODE_LSB = 10;
	localparam int SP_EQL_LSB = 0;
	localparam int SP_EQH_LSB = 2;
	localparam int SP_GAIN_LSB = 4;
	localparam int SP_DET_LSB = 6;
	localparam int SP_ADDR_LSB = 8;
	localparam int SP_DONE = 15;
	typedef enum logic [1:0] {
		RCD_IDLE = 2'h0,
		RCD_POLL = 2'h1,
		RCD_WAIT = 2'h3,
		RCD_FOUND = 2'h2
	} rcd_det_state_t;
endpackage

// file: verilog/rcd_redriver_ctrl.sv
// Purpose: Strap decode, configuration select, slave addresses and receiver detect of the redriver.
// Assumes: Four-level straps arrive already digitised as two-bit level codes.
// Notes: Straps other than the mode strap are captured once after reset release.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// - Pin mode: index is four times high plus low
// - Serial mode takes equalization from registers
// - Pin mode gain follows gain strap, default float
// - Detect starts at power-up, pin events, writes
// - Pin events start all; writes start chosen channels
// - Detect strap L0: machine off, fixed 50 ohm
// - Detect strap float: high-Z, poll every 150 us
// - Power-down high: reset channels, high-Z, standby
// - Resolve each four-level strap into four levels
// - Sample equalization, gain, detect straps once only
// - Mode strap evaluated continuously while running
// - Mode L2 makes the device a serial slave
// - Derive two slave addresses from mode, address straps
// - Mode L1, address L0 gives 0x18 and 0x19
// - Addresses step by two; upper bank one higher
module rcd_redriver_ctrl #(
	parameter int NUM_CH = rcd_pkg::NUM_CH,
	parameter int POLL_CYCLES = rcd_pkg::POLL_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [rcd_pkg::LVL_W-1:0] eq_strap_low,
	input wire logic [rcd_pkg::LVL_W-1:0] eq_strap_high,
	input wire logic [rcd_pkg::LVL_W-1:0] gain_strap,
	input wire logic [rcd_pkg::LVL_W-1:0] mode_strap,
	input wire logic [rcd_pkg::LVL_W-1:0] far_end_detect_strap,
	input wire logic [rcd_pkg::LVL_W-1:0] addr_strap,
	input wire logic power_down_pin,
	input wire logic mux_select_pin,
	input wire logic [NUM_CH-1:0] term_present,
	input wire logic [rcd_pkg::AVS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [rcd_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [rcd_pkg::BE_W-1:0] avs_byteenable,
	output logic [rcd_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [NUM_CH*rcd_pkg::EQ_W-1:0] equalization_index,
	output logic [rcd_pkg::LVL_W-1:0] flat_gain,
	output logic serial_mode,
	output logic [rcd_pkg::ADDR_W-1:0] addr_ch01,
	output logic [rcd_pkg::ADDR_W-1:0] addr_ch23,
	output logic standby,
	output logic [NUM_CH-1:0] rx_term_on,
	output logic [NUM_CH-1:0] tx_probe,
	output logic [NUM_CH-1:0] term_found
);
	localparam int LW = rcd_pkg::LVL_W;
	localparam int SYNC_W = 6 * LW + 2 + NUM_CH;

	// Levels are carried as two-bit codes L0..L3 = 00..11 from the pins onward.
	logic [SYNC_W-1:0] sync_out;
	logic [LW-1:0] eql_s, eqh_s, gain_s, mode_s, det_s, addr_s;
	logic pd_s, sel_s;
	logic [NUM_CH-1:0] term_s;

	rcd_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.din({term_present, mux_select_pin, power_down_pin, addr_strap, far_end_detect_strap, mode_strap,
			gain_strap, eq_strap_high, eq_strap_low}),
		.dout(sync_out)
	);

	assign {term_s, sel_s, pd_s, addr_s, det_s, mode_s, gain_s, eqh_s, eql_s} = sync_out;

	// Strap capture after reset release.
	logic [2:0] settle, next_settle;
	logic straps_done, next_straps_done;
	logic [LW-1:0] eq_low_lat, eq_high_lat, gain_lat, det_lat, addr_lat;
	logic [LW-1:0] next_eq_low_lat, next_eq_high_lat, next_gain_lat, next_det_lat, next_addr_lat;

	always_comb begin
		next_settle = settle;
		next_straps_done = straps_done;
		next_eq_low_lat = eq_low_lat;
		next_eq_high_lat = eq_high_lat;
		next_gain_lat = gain_lat;
		next_det_lat = det_lat;
		next_addr_lat = addr_lat;
		// The wait lets the synchroniser fill before the one and only sample.
		if (!straps_done) begin
			if (settle == rcd_pkg::STRAP_SETTLE_CYCLES) begin
				next_straps_done = 1'b1;
				next_eq_low_lat = eql_s;
				next_eq_high_lat = eqh_s;
				next_gain_lat = gain_s;
				next_det_lat = det_s;
				next_addr_lat = addr_s;
			end else begin
				next_settle = settle + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			settle <= '0;
			straps_done <= 1'b0;
			eq_low_lat <= rcd_pkg::LVL_L0;
			eq_high_lat <= rcd_pkg::LVL_L0;
			gain_lat <= rcd_pkg::LVL_L3;
			det_lat <= rcd_pkg::LVL_L3;
			addr_lat <= rcd_pkg::LVL_L0;
		end else begin
			settle <= next_settle;
			straps_done <= next_straps_done;
			eq_low_lat <= next_eq_low_lat;
			eq_high_lat <= next_eq_high_lat;
			gain_lat <= next_gain_lat;
			det_lat <= next_det_lat;
			addr_lat <= next_addr_lat;
		end
	end

	// Register map, byte offsets: CTRL holds one equalization index per channel in its low half and the gain code.
	// DET_TRIG is write-only; each set bit restarts detection on one channel, so links can be retrained one by one.
	// STATUS reports found and termination state per channel, standby, serial control and the live mode code.
	// STRAPS shows the captured strap codes and a capture-done flag, so firmware can confirm the power-up sample.
	// Unmapped offsets read zero and drop writes, which keeps the decode small at the cost of no error response.
	// Register slave. Every access answers one cycle after it is seen.
	logic [rcd_pkg::DATA_W-1:0] ctrl, next_ctrl, next_readdata;
	logic next_waitrequest;
	logic wr_accept, trig_write;

	assign wr_accept = avs_write && !avs_waitrequest;
	assign trig_write = wr_accept && avs_address == rcd_pkg::REG_DET_TRIG && avs_byteenable[0];

	always_comb begin
		next_ctrl = ctrl;
		next_readdata = avs_readdata;
		next_waitrequest = 1'b1;
		if ((avs_read || avs_write) && avs_waitrequest) begin
			next_waitrequest = 1'b0;
			next_readdata = '0;
			if (avs_read) begin
				unique case (avs_address)
					rcd_pkg::REG_CTRL: next_readdata = ctrl;
					rcd_pkg::REG_STATUS: begin
						next_readdata[rcd_pkg::ST_FOUND_LSB +: NUM_CH] = term_found;
						next_readdata[rcd_pkg::ST_TERM_LSB +: NUM_CH] = rx_term_on;
						next_readdata[rcd_pkg::ST_STANDBY] = standby;
						next_readdata[rcd_pkg::ST_SERIAL] = serial_mode;
						next_readdata[rcd_pkg::ST_MODE_LSB +: LW] = mode_s;
					end
					rcd_pkg::REG_STRAPS: begin
						next_readdata[rcd_pkg::SP_EQL_LSB +: LW] = eq_low_lat;
						next_readdata[rcd_pkg::SP_EQH_LSB +: LW] = eq_high_lat;
						next_readdata[rcd_pkg::SP_GAIN_LSB +: LW] = gain_lat;
						next_readdata[rcd_pkg::SP_DET_LSB +: LW] = det_lat;
						next_readdata[rcd_pkg::SP_ADDR_LSB +: LW] = addr_lat;
						next_readdata[rcd_pkg::SP_DONE] = straps_done;
					end
					default: next_readdata = '0;
				endcase
			end
		end
		if (wr_accept && avs_address == rcd_pkg::REG_CTRL) begin
			for (int b = 0; b < rcd_pkg::BE_W; b++) begin
				if (avs_byteenable[b]) begin
					next_ctrl[b*rcd_pkg::BYTE_W +: rcd_pkg::BYTE_W] = avs_writedata[b*rcd_pkg::BYTE_W +: rcd_pkg::BYTE_W];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= rcd_pkg::CTRL_RST;
			avs_readdata <= '0;
			avs_waitrequest <= 1'b1;
		end else begin
			ctrl <= next_ctrl;
			avs_readdata <= next_readdata;
			avs_waitrequest <= next_waitrequest;
		end
	end

	// Detect start events and the configuration outputs.
	logic pd_d, sel_d, all_evt;
	logic [NUM_CH-1:0] start_q, next_start;
	logic serial_now, next_serial_mode;
	logic [NUM_CH*rcd_pkg::EQ_W-1:0] next_equalization_index;
	logic [LW-1:0] next_flat_gain;
	logic [rcd_pkg::ADDR_W-1:0] next_addr_ch01;
	logic [2:0] addr_idx;

	// Pin events count only once the straps are captured: the edge detectors leave reset idle, and an early start
	// would reach the channels before the detect strap has chosen buffer mode. Power-up starts all channels anyway.
	assign all_evt = (!straps_done && next_straps_done)
		|| (straps_done && ((pd_d && !pd_s) || (sel_d ^ sel_s)));
	assign serial_now = (mode_s == rcd_pkg::LVL_L1) || (mode_s == rcd_pkg::LVL_L2);
	assign addr_idx = {mode_s == rcd_pkg::LVL_L2, addr_lat};

	always_comb begin
		next_start = {NUM_CH{all_evt}};
		if (trig_write) begin
			next_start = next_start | avs_writedata[NUM_CH-1:0];
		end
		next_serial_mode = serial_now;
		next_flat_gain = serial_now ? ctrl[rcd_pkg::CTRL_GAIN_LSB +: LW] : gain_lat;
		for (int c = 0; c < NUM_CH; c++) begin
			next_equalization_index[c*rcd_pkg::EQ_W +: rcd_pkg::EQ_W] =
				serial_now ? ctrl[c*rcd_pkg::EQ_W +: rcd_pkg::EQ_W] : {eq_high_lat, eq_low_lat};
		end
		next_addr_ch01 = rcd_pkg::SLAVE_ADDR_BASE + rcd_pkg::ADDR_W'({addr_idx, 1'b0});
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pd_d <= 1'b0;
			sel_d <= 1'b0;
			start_q <= '0;
			serial_mode <= 1'b0;
			flat_gain <= rcd_pkg::LVL_L3;
			equalization_index <= '0;
			addr_ch01 <= rcd_pkg::SLAVE_ADDR_BASE;
			addr_ch23 <= rcd_pkg::SLAVE_ADDR_BASE | rcd_pkg::SLAVE_ADDR_BANK_HI;
			standby <= 1'b0;
		end else begin
			pd_d <= pd_s;
			sel_d <= sel_s;
			start_q <= next_start;
			serial_mode <= next_serial_mode;
			flat_gain <= next_flat_gain;
			equalization_index <= next_equalization_index;
			addr_ch01 <= next_addr_ch01;
			addr_ch23 <= next_addr_ch01 | rcd_pkg::SLAVE_ADDR_BANK_HI;
			standby <= pd_s;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
			rcd_detect_chan #(
				.POLL_CYCLES(POLL_CYCLES)
			) u_det (
				.clk(clk),
				.nrst(nrst),
				.start(start_q[ch]),
				.buffer_mode(det_lat == rcd_pkg::LVL_L0),
				.standby(standby),
				.term_present(term_s[ch]),
				.tx_probe(tx_probe[ch]),
				.rx_term_on(rx_term_on[ch]),
				.term_found(term_found[ch])
			);
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_EQ_PIN: assert property (straps_done && !serial_now |=> equalization_index[rcd_pkg::EQ_W-1:0] == {eq_high_lat, eq_low_lat}) else $error("pin equalization index wrong");
	AST_EQ_SERIAL: assert property (serial_now |=> equalization_index[rcd_pkg::EQ_W-1:0] == $past(ctrl[rcd_pkg::EQ_W-1:0])) else $error("serial equalization not from register");
	AST_GAIN_PIN: assert property (!serial_now |=> flat_gain == $past(gain_lat)) else $error("pin gain wrong");
	AST_PWRUP_ALL: assert property ((!straps_done && settle == rcd_pkg::STRAP_SETTLE_CYCLES) |=> (&start_q)) else $error("power-up did not start all channels");
	AST_PD_EVT: assert property ((straps_done && $fell(pd_s)) |=> (&start_q)) else $error("power-down release did not start detect");
	AST_TRIG_CH: assert property (trig_write |=> ($past(avs_writedata[0]) -> start_q[0])) else $error("register trigger lost");
	AST_STRAP_FROZEN: assert property (straps_done |=> ($stable(eq_low_lat) && $stable(eq_high_lat) && $stable(gain_lat) && $stable(det_lat))) else $error("latched strap changed");
	AST_MODE_LIVE: assert property ((mode_s == rcd_pkg::LVL_L2) ##1 (mode_s == rcd_pkg::LVL_L0) |=> (!serial_mode && $past(serial_mode))) else $error("mode change not followed");
	AST_ADDR_BASE: assert property ((mode_s == rcd_pkg::LVL_L1 && addr_lat == rcd_pkg::LVL_L0) |=> (addr_ch01 == rcd_pkg::SLAVE_ADDR_BASE && addr_ch23 == (rcd_pkg::SLAVE_ADDR_BASE | rcd_pkg::SLAVE_ADDR_BANK_HI))) else $error("base address wrong");
	AST_ADDR_TOP: assert property ((mode_s == rcd_pkg::LVL_L2 && addr_lat == rcd_pkg::LVL_L3) |=> (addr_ch01 == rcd_pkg::SLAVE_ADDR_TOP && addr_ch23 == (addr_ch01 | rcd_pkg::SLAVE_ADDR_BANK_HI))) else $error("top address wrong");
	AST_STANDBY: assert property (pd_s |=> standby ##1 (rx_term_on == '0)) else $error("standby not entered");
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");

	// Start events, configuration and bus answers are checked at the register that carries them, one edge later.
	AST_NO_EARLY_START: assert property (
		!straps_done && !next_straps_done && !trig_write |=> start_q == '0
	) else $error("detect started before strap capture");
	AST_SEL_EVT: assert property (
		straps_done && (sel_d != sel_s) |=> &start_q
	) else $error("mux select edge did not start all channels");
	AST_SERIAL_L2: assert property (
		mode_s == rcd_pkg::LVL_L2 |=> serial_mode
	) else $error("mode L2 did not select serial control");
	AST_PIN_L0: assert property (
		mode_s == rcd_pkg::LVL_L0 |=> !serial_mode
	) else $error("mode L0 did not select pin control");
	AST_GAIN_SERIAL: assert property (
		serial_now |=> flat_gain == $past(ctrl[rcd_pkg::CTRL_GAIN_LSB +: LW])
	) else $error("serial gain not from register");
	AST_CAPTURE_ONCE: assert property (
		straps_done |=> straps_done
	) else $error("strap capture repeated");
	AST_BUS_ACK: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
	) else $error("access not answered after one wait cycle");
	AST_STANDBY_OFF: assert property (
		!pd_s |=> !standby
	) else $error("standby held without power-down");
	AST_CTRL_WRITE: assert property (
		wr_accept && avs_address == rcd_pkg::REG_CTRL && (&avs_byteenable) |=> ctrl == $past(avs_writedata)
	) else $error("full control write not stored");
	AST_EQ_TOP_CH: assert property (
		straps_done && !serial_now
			|=> equalization_index[NUM_CH*rcd_pkg::EQ_W-1 -: rcd_pkg::EQ_W] == {eq_high_lat, eq_low_lat}
	) else $error("pin equalization index of top channel wrong");
	AST_STANDBY_PROBE: assert property (
		standby |=> tx_probe == '0
	) else $error("probe issued in standby");
	AST_UNMAPPED_RD: assert property (
		avs_read && avs_waitrequest && avs_address == rcd_pkg::REG_DET_TRIG |=> avs_readdata == '0
	) else $error("trigger register read not zero");
	AST_FOUND_HOLD: assert property (
		term_found[0] && !standby && !start_q[0] && det_lat != rcd_pkg::LVL_L0 |=> term_found[0]
	) else $error("found result lost without a cause");
endmodule // rcd_redriver_ctrl

// file: verilog/rcd_sync.sv
// Purpose: Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes: Each bit is an independent level; bundles are not coherent words.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module rcd_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // rcd_sync
